// File: include/frs_pkg.sv
// constants and types for the floppy rate config and result status block
// Operation
// (R1) second-gen view bits 2:1 give rate; soft resets keep it, hard reset 250k
// (R2) second-gen view bits 6:3 always read one
// (R3) view bit 7 is the inverse of the synchronised media-changed pin
// (R4) compact view bit 3 echoes the dma gate enable of output control
// (R5) compact view bit 2 echoes the last written precomp disable bit
// (R6) compact view bits 6:4 always read zero
// (R7) compact view bits 1:0 give rate; soft resets keep it, hard reset 250k
// (R8) writes to the view address land in config control; bits 1:0 set rate
// (R9) host writes zero to reserved config control bits
// (R10) compact config control bit 2 is a stored, inert precomp disable bit
// (R11) density pin goes high on hard reset and ignores soft resets
// (R12) result phase hands status bytes of the last command through the data port
// (R13) status 0 bits 7:6 hold the termination code
// (R14) status 0 bit 5 flags a finished seek or recalibrate
// (R15) status 0 bit 4 flags no track zero after 80 steps or outward overrun
// (R16) status 0 bit 3 zero, bit 2 head, bits 1:0 selected drive
// (R17) status 1 bit 7 flags past last sector or data command ending without tc
// (R18) status 1 bit 5 flags crc fault; bits 6 and 3 read zero
// (R19) status 1 bit 4 flags data overrun or underrun
// (R20) status 1 bit 2 flags missing sector, bad id, or bad track sequence
// (R21) status 1 bit 1 flags write protect high during a write command
// (R22) status 1 bit 0 flags no id mark after two index pulses or no data mark
// (R23) mode follows config bits 6 and 5: baseline, second-gen, compact
// (R24) second-gen view bit 0 low for 500k or 1M, high for 250k or 300k
// (R25) config control and rate select share one stored rate setting
package frs_pkg;
    localparam int ADR_W = 14;
    localparam int WB_DW = 32;
    localparam int SEL_W = 4;
    localparam int BYTE_W = 8;
    localparam int IDX_LSB = 2;
    localparam int IDX_W = 12;
    // register word indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_MODE = 12'h3F0;
    localparam logic [IDX_W-1:0] IDX_STATE = 12'h3F1;
    localparam logic [IDX_W-1:0] IDX_OUTCTL = 12'h3F2;
    localparam logic [IDX_W-1:0] IDX_RATESEL = 12'h3F4;
    localparam logic [IDX_W-1:0] IDX_RESULT = 12'h3F5;
    localparam logic [IDX_W-1:0] IDX_VIEW = 12'h3F7;
    // rate select codes
    localparam int RATE_W = 2;
    localparam logic [RATE_W-1:0] RATE_500K = 2'h0;
    localparam logic [RATE_W-1:0] RATE_300K = 2'h1;
    localparam logic [RATE_W-1:0] RATE_250K = 2'h2;
    localparam logic [RATE_W-1:0] RATE_1M = 2'h3;
    localparam logic [RATE_W-1:0] RATE_RST = RATE_250K;
    // field positions
    localparam int CC_PRECOMP = 2;
    localparam int OC_RESET_N = 2;
    localparam int OC_DMA = 3;
    localparam int RS_SWRST = 7;
    localparam int MODE_SEL_BIT = 6;
    localparam int MODE_ENC_BIT = 5;
    localparam logic [BYTE_W-1:0] OUTCTL_RST = 8'h00;
    localparam logic [BYTE_W-1:0] MODE_RST = 8'h40;
    localparam logic [3:0] GEN2_FILL = 4'hF;
    localparam logic [2:0] COMPACT_FILL = 3'h0;
    // flag slots of the accumulated status
    localparam int FLAG_W = 8;
    localparam int F_POS = 0;
    localparam int F_TZF = 1;
    localparam int F_EOC = 2;
    localparam int F_CRC = 3;
    localparam int F_OVR = 4;
    localparam int F_NSEC = 5;
    localparam int F_WBLK = 6;
    localparam int F_MARK = 7;
    // synchronised pin slots
    localparam int PIN_W = 4;
    localparam int PIN_MC = 0;
    localparam int PIN_TRACK_ZERO_INPUT = 1;
    localparam int PIN_WP = 2;
    localparam int PIN_IDX = 3;
    localparam logic [6:0] RECAL_STEPS = 7'd80;
    localparam logic [1:0] INDEX_LIMIT = 2'd2;

    typedef enum logic [1:0] {
        MODE_BASE = 2'b00,
        MODE_GEN2 = 2'b01,
        MODE_COMPACT = 2'b10
    } frs_mode_t;

    typedef enum logic [1:0] {
        TERM_NORMAL = 2'b00,
        TERM_ABORT = 2'b01,
        TERM_INVALID = 2'b10,
        TERM_POLL = 2'b11
    } frs_term_t;

    typedef enum logic [1:0] {
        RPH_IDLE = 2'b00,
        RPH_BYTE0 = 2'b01,
        RPH_BYTE1 = 2'b10
    } frs_rph_t;
endpackage : frs_pkg

// File: design/frs_sync.sv
// two flip-flop synchroniser for the drive cable inputs
`timescale 1ns/1ps
module frs_sync #(
    parameter int W = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= '0;
            q_o <= '0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule : frs_sync

// File: design/frs_top.sv
// rate configuration, input view and result status bytes of the floppy controller
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module frs_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [frs_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [frs_pkg::SEL_W-1:0] wb_sel_i,
    input wire logic [frs_pkg::WB_DW-1:0] wb_dat_i,
    output logic [frs_pkg::WB_DW-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic media_changed_i,
    input wire logic track_zero_input_i,
    input wire logic write_protect_i,
    input wire logic index_pulse_input_i,
    output logic density_output_o,
    input wire logic result_start_i,
    input wire frs_pkg::frs_term_t termination_code_i,
    input wire logic head_addr_i,
    input wire logic positioning_done_i,
    input wire logic recal_active_i,
    input wire logic step_pulse_i,
    input wire logic outward_past_zero_i,
    input wire logic past_last_sector_i,
    input wire logic data_cmd_end_i,
    input wire logic transfer_count_end_i,
    input wire logic crc_fault_i,
    input wire logic overrun_i,
    input wire logic sector_missing_i,
    input wire logic write_cmd_active_i,
    input wire logic id_search_i,
    input wire logic no_data_mark_i,
    output logic [frs_pkg::RATE_W-1:0] rate_select_field_o,
    output logic dma_gate_enable_o,
    output logic [1:0] drive_select_echo_o,
    output logic soft_reset_o,
    output logic result_phase_o
);
    import frs_pkg::*;

    function automatic logic reg_hit(input logic [ADR_W-1:0] adr,
                                     input logic [IDX_W-1:0] idx);
        reg_hit = (adr[ADR_W-1:IDX_LSB] == idx);
    endfunction : reg_hit

    function automatic frs_mode_t mode_of(input logic [BYTE_W-1:0] cfg);
        if (cfg[MODE_SEL_BIT]) begin
            mode_of = MODE_BASE;
        end else if (cfg[MODE_ENC_BIT]) begin
            mode_of = MODE_GEN2;
        end else begin
            mode_of = MODE_COMPACT;
        end
    endfunction : mode_of

    function automatic logic fast_rate(input logic [RATE_W-1:0] r);
        fast_rate = (r == RATE_500K) || (r == RATE_1M);
    endfunction : fast_rate

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s;
    logic mc_s;
    logic track_zero_input_s;
    logic wp_s;
    logic idx_s;

    assign pin_raw[PIN_MC] = media_changed_i;
    assign pin_raw[PIN_TRACK_ZERO_INPUT] = track_zero_input_i;
    assign pin_raw[PIN_WP] = write_protect_i;
    assign pin_raw[PIN_IDX] = index_pulse_input_i;

    frs_sync #(
        .W(PIN_W)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(pin_raw),
        .q_o(pin_s)
    );

    assign mc_s = pin_s[PIN_MC];
    assign track_zero_input_s = pin_s[PIN_TRACK_ZERO_INPUT];
    assign wp_s = pin_s[PIN_WP];
    assign idx_s = pin_s[PIN_IDX];

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave: one wait-free answer, ack in the cycle after the request
    logic ack_r;
    logic [WB_DW-1:0] dat_r;
    logic req;
    logic rd_req;
    logic wr_go;
    logic rd_go;
    logic hit_view;
    logic hit_outctl;
    logic hit_rsel;
    logic hit_mode;
    logic hit_result;
    logic hit_state;

    assign req = wb_cyc_i & wb_stb_i;
    assign rd_req = req & ~ack_r & ~wb_we_i;
    // effects land on the edge where the master samples ack
    assign wr_go = req & ack_r & wb_we_i & wb_sel_i[0];
    assign rd_go = req & ack_r & ~wb_we_i;
    assign hit_view = reg_hit(wb_adr_i, IDX_VIEW);
    assign hit_outctl = reg_hit(wb_adr_i, IDX_OUTCTL);
    assign hit_rsel = reg_hit(wb_adr_i, IDX_RATESEL);
    assign hit_mode = reg_hit(wb_adr_i, IDX_MODE);
    assign hit_result = reg_hit(wb_adr_i, IDX_RESULT);
    assign hit_state = reg_hit(wb_adr_i, IDX_STATE);
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    ////////////////////////////////////////////////////////////////////////
    // configuration state
    logic [RATE_W-1:0] rate_r;
    logic [RATE_W-1:0] rate_nxt;
    logic precomp_r;
    logic [BYTE_W-1:0] outctl_r;
    logic [BYTE_W-1:0] mode_r;
    logic swrst_r;
    logic dens_hold_r;
    logic dens_r;
    logic rate_wr;
    logic soft_rst;
    frs_mode_t mode;

    assign mode = mode_of(mode_r); // R23
    // one stored rate, written from either address
    assign rate_wr = wr_go & (hit_view | hit_rsel); // R8 R25
    assign rate_nxt = rate_wr ? wb_dat_i[RATE_W-1:0] : rate_r; // R8 R25
    // output-control reset bit is active low; rate-select reset clears itself
    assign soft_rst = ~outctl_r[OC_RESET_N] | swrst_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rate_r <= RATE_RST; // R1 R7
            precomp_r <= 1'b0;
            outctl_r <= OUTCTL_RST;
            mode_r <= MODE_RST;
            swrst_r <= 1'b0;
        end else begin
            // soft resets deliberately leave these alone
            rate_r <= rate_nxt; // R1 R7
            if (wr_go & hit_view & (mode == MODE_COMPACT)) begin
                precomp_r <= wb_dat_i[CC_PRECOMP]; // R10 R5
            end
            if (wr_go & hit_outctl) begin
                outctl_r <= wb_dat_i[BYTE_W-1:0];
            end
            if (wr_go & hit_mode) begin
                mode_r <= wb_dat_i[BYTE_W-1:0]; // R23
            end
            swrst_r <= wr_go & hit_rsel & wb_dat_i[RS_SWRST];
        end
    end

    // density stays high from hard reset until software picks a rate
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dens_hold_r <= 1'b1; // R11
            dens_r <= 1'b1; // R11
        end else begin
            dens_hold_r <= dens_hold_r & ~rate_wr;
            if (~dens_hold_r | rate_wr) begin
                dens_r <= mode_r[MODE_SEL_BIT] ? fast_rate(rate_nxt)
                                               : ~fast_rate(rate_nxt);
            end
        end
    end

    assign density_output_o = dens_r;
    assign rate_select_field_o = rate_r;
    assign dma_gate_enable_o = outctl_r[OC_DMA];
    assign drive_select_echo_o = outctl_r[1:0];
    assign soft_reset_o = soft_rst;

    ////////////////////////////////////////////////////////////////////////
    // status event capture; a set arriving with the clear survives
    logic [FLAG_W-1:0] fl_r;
    logic [FLAG_W-1:0] fl_set;
    logic fl_clr;
    logic tc_seen_r;
    logic [6:0] step_cnt_r;
    logic [1:0] idx_cnt_r;
    logic idx_d_r;
    logic idx_rise;
    logic recal_fail;

    assign fl_clr = result_start_i | soft_rst;
    assign idx_rise = idx_s & ~idx_d_r;
    assign recal_fail = recal_active_i & step_pulse_i & ~track_zero_input_s &
                        (step_cnt_r == RECAL_STEPS - 7'd1); // R15

    assign fl_set[F_POS] = positioning_done_i; // R14
    assign fl_set[F_TZF] = recal_fail | outward_past_zero_i; // R15
    assign fl_set[F_EOC] = past_last_sector_i |
        (data_cmd_end_i & ~tc_seen_r & ~transfer_count_end_i); // R17
    assign fl_set[F_CRC] = crc_fault_i; // R18
    assign fl_set[F_OVR] = overrun_i; // R19
    assign fl_set[F_NSEC] = sector_missing_i; // R20
    assign fl_set[F_WBLK] = wp_s & write_cmd_active_i; // R21
    assign fl_set[F_MARK] = no_data_mark_i |
        (id_search_i & idx_rise & (idx_cnt_r == INDEX_LIMIT - 2'd1)); // R22

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fl_r <= '0;
            tc_seen_r <= 1'b0;
            idx_d_r <= 1'b0;
        end else begin
            fl_r <= fl_set | (fl_r & ~{FLAG_W{fl_clr}});
            tc_seen_r <= transfer_count_end_i |
                         (tc_seen_r & ~fl_clr & ~data_cmd_end_i);
            idx_d_r <= idx_s;
        end
    end

    // step and index counters restart whenever their command is not active
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            step_cnt_r <= '0;
            idx_cnt_r <= '0;
        end else begin
            if (~recal_active_i) begin
                step_cnt_r <= '0;
            end else if (step_pulse_i & (step_cnt_r != RECAL_STEPS)) begin
                step_cnt_r <= step_cnt_r + 7'd1; // R15
            end
            if (~id_search_i) begin
                idx_cnt_r <= '0;
            end else if (idx_rise & (idx_cnt_r != INDEX_LIMIT)) begin
                idx_cnt_r <= idx_cnt_r + 2'd1; // R22
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result phase: two status bytes read in order through the result port
    logic [BYTE_W-1:0] st0_r;
    logic [BYTE_W-1:0] st1_r;
    logic [BYTE_W-1:0] st0_b;
    logic [BYTE_W-1:0] st1_b;
    frs_rph_t rph_r;
    frs_rph_t rph_nxt;
    logic pop;

    assign st0_b = {termination_code_i, fl_r[F_POS], fl_r[F_TZF], 1'b0,
                    head_addr_i, outctl_r[1:0]}; // R13 R14 R15 R16
    assign st1_b = {fl_r[F_EOC], 1'b0, fl_r[F_CRC], fl_r[F_OVR], 1'b0,
                    fl_r[F_NSEC], fl_r[F_WBLK], fl_r[F_MARK]}; // R17 R18 R19 R20 R21 R22
    assign pop = rd_go & hit_result;

    always_comb begin
        rph_nxt = rph_r;
        if (soft_rst) begin
            rph_nxt = RPH_IDLE;
        end else if (result_start_i) begin
            rph_nxt = RPH_BYTE0; // R12
        end else begin
            case (rph_r)
                RPH_BYTE0: begin
                    if (pop) begin
                        rph_nxt = RPH_BYTE1;
                    end
                end
                RPH_BYTE1: begin
                    if (pop) begin
                        rph_nxt = RPH_IDLE;
                    end
                end
                default: begin
                    rph_nxt = RPH_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rph_r <= RPH_IDLE;
            st0_r <= '0;
            st1_r <= '0;
        end else begin
            rph_r <= rph_nxt;
            if (result_start_i) begin
                st0_r <= st0_b; // R12
                st1_r <= st1_b; // R12
            end
        end
    end

    assign result_phase_o = (rph_r != RPH_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // read data
    logic [BYTE_W-1:0] view_b;
    logic [BYTE_W-1:0] rd_byte;

    always_comb begin
        case (mode)
            MODE_GEN2: begin
                view_b = {~mc_s, GEN2_FILL, rate_r,
                          ~fast_rate(rate_r)}; // R1 R2 R3 R24
            end
            MODE_COMPACT: begin
                view_b = {~mc_s, COMPACT_FILL, outctl_r[OC_DMA], precomp_r,
                          rate_r}; // R3 R4 R5 R6 R7
            end
            default: begin
                // undefined low bits in baseline mode read as zero
                view_b = {~mc_s, 7'h00}; // R3
            end
        endcase
    end

    always_comb begin
        rd_byte = '0;
        if (hit_view) begin
            rd_byte = view_b;
        end else if (hit_outctl) begin
            rd_byte = outctl_r;
        end else if (hit_rsel) begin
            rd_byte = {{(BYTE_W-RATE_W){1'b0}}, rate_r};
        end else if (hit_mode) begin
            rd_byte = mode_r;
        end else if (hit_result) begin
            if (rph_r == RPH_BYTE0) begin
                rd_byte = st0_r; // R12
            end else if (rph_r == RPH_BYTE1) begin
                rd_byte = st1_r; // R12
            end
        end else if (hit_state) begin
            rd_byte = {{(BYTE_W-2){1'b0}}, soft_rst, result_phase_o};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= '0;
        end else begin
            ack_r <= req & ~ack_r;
            if (rd_req) begin
                dat_r <= {{(WB_DW-BYTE_W){1'b0}}, rd_byte};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic rd_view_ack;
    assign rd_view_ack = ack_r & req & ~wb_we_i & hit_view;

    sequence s_pop0;
        pop & (rph_r == RPH_BYTE0) & ~result_start_i & ~soft_rst;
    endsequence

    sequence s_pop1;
        pop & (rph_r == RPH_BYTE1) & ~result_start_i & ~soft_rst;
    endsequence

    gen2_fill_a: assert property ( // R2
        rd_view_ack & (mode == MODE_GEN2) |-> (wb_dat_o[6:3] == GEN2_FILL) &&
        (wb_dat_o[0] == ~fast_rate(rate_r)))
        else $error("second-gen view fill or low-rate bit wrong");

    compact_view_a: assert property ( // R6
        rd_view_ack & (mode == MODE_COMPACT) |-> (wb_dat_o[6:4] == COMPACT_FILL) &&
        (wb_dat_o[3] == outctl_r[OC_DMA]) && (wb_dat_o[2] == precomp_r))
        else $error("compact view bits wrong");

    media_inv_a: assert property ( // R3
        rd_view_ack |-> wb_dat_o[7] == ~$past(mc_s))
        else $error("media changed bit not inverted");

    ccr_rate_a: assert property ( // R8
        wr_go & hit_view |=> rate_r == $past(wb_dat_i[RATE_W-1:0]))
        else $error("config control write did not set rate");

    rate_keep_a: assert property ( // R1
        soft_rst & ~rate_wr |=> $stable(rate_r) && $stable(precomp_r))
        else $error("soft reset disturbed rate or precomp");

    density_rst_a: assert property ( // R11
        $fell(rst_i) |-> density_output_o ##1 (density_output_o || $past(rate_wr)))
        else $error("density not high after hard reset");

    st0_code_a: assert property ( // R13
        result_start_i & ~soft_rst |=> (st0_r[7:6] == $past(termination_code_i)) &&
        ~st0_r[3] && (rph_r == RPH_BYTE0))
        else $error("status 0 not captured");

    eoc_tc_a: assert property ( // R17
        data_cmd_end_i & ~tc_seen_r & ~transfer_count_end_i |=> fl_r[F_EOC])
        else $error("missing tc did not flag end of track");

    recal_fault_a: assert property ( // R15
        recal_fail |=> fl_r[F_TZF])
        else $error("recalibrate fault not flagged");

    result_order_a: assert property ( // R12
        s_pop1 |-> wb_dat_o[BYTE_W-1:0] == st1_r)
        else $error("second result byte not returned in order");

    pop_next_a: assert property ( // R12
        s_pop0 |=> rph_r == RPH_BYTE1)
        else $error("result byte order broken");

    pop_done_a: assert property ( // R12
        s_pop1 |=> ~result_phase_o)
        else $error("result phase did not end after second byte");
endmodule : frs_top

// File: verification/frs_host.sv
// host processor model issuing classic wishbone single cycles
`timescale 1ns/1ps
module frs_host (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic we_o,
    output logic [13:0] adr_o,
    output logic [31:0] dat_o
);
    initial begin
        cyc_o = 1'b0;
        we_o = 1'b0;
        adr_o = 14'h0000;
        dat_o = 32'h00000000;
    end
    // request held until the edge that samples ack; bounded wait reports failure
    task automatic xfer(input logic w, input logic [13:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ok);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        dat_o <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_i !== 1'b1 && n < 16);
        q = dat_i[7:0];
        ok = (ack_i === 1'b1);
        cyc_o <= 1'b0;
        we_o <= 1'b0;
    endtask : xfer
endmodule : frs_host

// File: verification/fdc_rate_config_and_result_status_tb.sv
// self-checking bench for the rate config and result status block
`timescale 1ns/1ps
module fdc_rate_config_and_result_status_tb;
    import frs_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, we, ack, dens, dma_o, srst, rph, d0;
    logic mc = 1'b0, wp = 1'b0, rs = 1'b0, head = 1'b0, recal = 1'b0, step = 1'b0;
    logic tc = 1'b0, wact = 1'b0, dm, pr, tz, eoc;
    logic idx = 1'b0, tk = 1'b0, ids = 1'b0;
    logic [7:0] ev = 8'h00, q;
    logic [13:0] adr;
    logic [31:0] wdat, rdat, e, rnd = 32'h34DB;
    logic [1:0] rate_o, drv, r2, dse;
    frs_term_t term = TERM_NORMAL;
    int err_count = 0, comparisons = 0, n;

    always #10 clk_i = ~clk_i;

    frs_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .media_changed_i(mc), .track_zero_input_i(tk),
        .write_protect_i(wp), .index_pulse_input_i(idx), .density_output_o(dens),
        .result_start_i(rs), .termination_code_i(term), .head_addr_i(head),
        .positioning_done_i(ev[0]), .recal_active_i(recal), .step_pulse_i(step),
        .outward_past_zero_i(ev[1]), .past_last_sector_i(ev[2]), .data_cmd_end_i(ev[7]),
        .transfer_count_end_i(tc), .crc_fault_i(ev[3]), .overrun_i(ev[4]),
        .sector_missing_i(ev[5]), .write_cmd_active_i(wact), .id_search_i(ids),
        .no_data_mark_i(ev[6]), .rate_select_field_o(rate_o), .dma_gate_enable_o(dma_o),
        .drive_select_echo_o(dse), .soft_reset_o(srst), .result_phase_o(rph));
    frs_host host_u (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .we_o(we),
        .adr_o(adr), .dat_o(wdat));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    // low-rate codes: 250k and 300k
    function automatic logic slow(input logic [1:0] r);
        return (r == RATE_250K) || (r == RATE_300K);
    endfunction : slow

    task automatic close_out();
        if (err_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [11:0] i, input logic [7:0] d);
        logic ok;
        host_u.xfer(w, {i, 2'b00}, d, q, ok);
        if (ok !== 1'b1) begin
            err_count++;
            close_out();
        end
    endtask : bus

    task automatic wr(input logic [11:0] i, input logic [7:0] d);
        bus(1'b1, i, d);
    endtask : wr

    task automatic rd(input logic [11:0] i, input logic [7:0] exp);
        bus(1'b0, i, 8'h00);
        chk({24'h000000, q}, {24'h000000, exp});
    endtask : rd

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(dens, 1'b1);
        rd(12'h3F3, 8'h00);
        rd(IDX_VIEW, {~mc, 7'h00});
        wr(IDX_MODE, 8'h20);
        for (int k = 0; k < 8; k++) begin
            rnd = lfsr(rnd);
            r2 = k[1:0];
            mc <= rnd[2];
            if (k[0]) wr(IDX_VIEW, {6'h00, r2});
            else wr(IDX_RATESEL, {6'h00, r2});
            rd(IDX_VIEW, {~mc, 4'hF, r2, slow(r2)});
        end
        wr(IDX_MODE, 8'h00);
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            {dm, pr, r2} = rnd[3:0];
            mc <= rnd[4];
            wr(IDX_OUTCTL, {4'h0, dm, 3'h4});
            wr(IDX_VIEW, {5'h00, pr, r2});
            chk(dma_o, dm);
            rd(IDX_VIEW, {~mc, 3'h0, dm, pr, r2});
            chk(dens, slow(r2));
            d0 = dens;
            wr(IDX_OUTCTL, 8'h00);
            wr(IDX_OUTCTL, {4'h0, dm, 3'h4});
            wr(IDX_RATESEL, {6'h20, r2});
            rd(IDX_VIEW, {~mc, 3'h0, dm, pr, r2});
            chk(dens, d0);
        end
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({srst, dens, rate_o}, {2'b11, RATE_RST});
        wr(IDX_MODE, 8'h00);
        rd(IDX_VIEW, {~mc, 5'h00, RATE_RST});
        for (int k = 0; k < 6; k++) begin
            rnd = lfsr(rnd);
            e = rnd;
            drv = e[15:14];
            wr(IDX_OUTCTL, {6'h01, drv});
            @(posedge clk_i);
            chk({srst, dma_o, dse}, {2'b00, drv});
            tc <= e[8];
            @(posedge clk_i);
            tc <= 1'b0;
            ev <= e[7:0];
            @(posedge clk_i);
            ev <= 8'h00;
            wp <= e[9];
            wact <= 1'b1;
            repeat (4) @(posedge clk_i);
            wact <= 1'b0;
            wp <= 1'b0;
            // one or two index pulses while the id search runs
            ids <= 1'b1;
            repeat (1 + e[16]) begin
                repeat (3) @(posedge clk_i);
                idx <= 1'b1;
                repeat (3) @(posedge clk_i);
                idx <= 1'b0;
            end
            repeat (3) @(posedge clk_i);
            ids <= 1'b0;
            recal <= 1'b1;
            tk <= e[17];
            n = 79 + e[10];
            repeat (n) begin
                @(posedge clk_i);
                step <= 1'b1;
                @(posedge clk_i);
                step <= 1'b0;
            end
            recal <= 1'b0;
            tk <= 1'b0;
            term <= frs_term_t'(e[12:11]);
            head <= e[13];
            tz = ((n == 80) & ~e[17]) | e[1];
            eoc = e[2] | (e[7] & ~e[8]);
            @(posedge clk_i);
            rs <= 1'b1;
            @(posedge clk_i);
            rs <= 1'b0;
            @(posedge clk_i);
            chk(rph, 1'b1);
            rd(IDX_RESULT, {e[12:11], e[0], tz, 1'b0, e[13], drv});
            rd(IDX_RESULT, {eoc, 1'b0, e[3], e[4], 1'b0, e[5], e[9], e[6] | e[16]});
            // the phase drops on the edge that ends the read; look one edge later
            @(posedge clk_i);
            chk(rph, 1'b0);
        end
        close_out();
    end
endmodule : fdc_rate_config_and_result_status_tb
